/* File: hdl/utc_model_track.sv */
`timescale 1ns/1ps
module utc_model_track
  import utc_pkg::*;
#(
  parameter int UNITS_P = UNITS
)
(
  // System
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Pins as driven
  utc_pin_if.mon pins,
  // Power-up and expected state
  input wire logic [CODE_W-1:0] recall_code,
  input wire logic recall_load,
  output logic [CODE_W-1:0] live_code,
  output logic [CODE_W-1:0] stored_code,
  output logic [UNITS_P-1:0] unit_en
);
  typedef struct packed {
    logic [CODE_W-1:0] live;
    logic [CODE_W-1:0] stored;
    logic sel_n;
    logic step_n;
    logic [UNITS_P-1:0] en;
  } utc_trk_s;

  utc_trk_s st_q;
  utc_trk_s st_d;
  logic [UNITS_P-1:0] therm;

  // Thermometer decode: code n lights exactly n units
  for (genvar i = 0; i < UNITS_P; i++)
  begin : g_unit
    assign therm[i] = (32'(st_d.live) > i);
  end

  always_comb
  begin
    st_d = st_q;
    st_d.sel_n = pins.sel_n;
    st_d.step_n = pins.step_n;
    if (recall_load)
    begin
      st_d.live = recall_code;
      st_d.stored = recall_code;
    end
    else if (!pins.sel_n && st_q.step_n && !pins.step_n)
    begin
      if (pins.dir_up && st_q.live != CODE_MAX)
        st_d.live = st_q.live + CODE_ONE;
      else if (!pins.dir_up && st_q.live != CODE_MIN)
        st_d.live = st_q.live - CODE_ONE;
    end
    if (!st_q.sel_n && pins.sel_n && pins.step_n)
      st_d.stored = st_q.live;
    st_d.en = therm;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      st_q <= '{live: CODE_MIN, stored: CODE_MIN, sel_n: 1'b1, step_n: 1'b1, en: '0};
    else if (ce)
      st_q <= st_d;
  end

  assign live_code = st_q.live;
  assign stored_code = st_q.stored;
  assign unit_en = st_q.en;

  a_code_saturate_up: assert property (@(posedge clk) disable iff (rst)
    ce && !recall_load && st_q.live == CODE_MAX && !pins.sel_n && pins.dir_up
    |=> st_q.live == CODE_MAX)
    else $error("Code wrapped above top");
  a_code_saturate_dn: assert property (@(posedge clk) disable iff (rst)
    ce && !recall_load && st_q.live == CODE_MIN && !pins.sel_n && !pins.dir_up
    |=> st_q.live == CODE_MIN)
    else $error("Code wrapped below zero");
  a_units_match_code: assert property (@(posedge clk) disable iff (rst)
    ce |-> $countones(st_q.en) == 32'(st_q.live))
    else $error("Unit count differs from code");
  a_ignore_when_idle: assert property (@(posedge clk) disable iff (rst)
    ce && !recall_load && st_q.sel_n && pins.sel_n |=> $stable(st_q.live))
    else $error("Code moved while deselected");
endmodule

/* File: hdl/utc_trim_host.sv */
`timescale 1ns/1ps
module utc_trim_host
  import utc_pkg::*;
#(
  parameter int STORE_WAIT_CYC = CYC_STORE_WAIT,
  parameter int UNITS_P = UNITS
)
(
  // System
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Command
  input wire logic cmd_valid,
  input wire logic [CODE_W-1:0] cmd_code,
  input wire logic cmd_store,
  output logic cmd_ready,
  // Device pins
  output logic sel_n,
  output logic step_n,
  output logic dir_up,
  // Power-up recall of the value held in the device
  input wire logic [CODE_W-1:0] recall_code,
  input wire logic recall_load,
  // Status
  output logic busy,
  output logic [CODE_W-1:0] cur_code,
  output logic [CODE_W-1:0] nv_code,
  output logic [UNITS_P-1:0] unit_en
);
  typedef struct packed {
    utc_state_e fsm;
    logic [TMR_W-1:0] tmr;
    logic [CODE_W-1:0] target;
    logic store;
    logic sel_n;
    logic step_n;
    logic dir_up;
  } utc_host_s;

  localparam logic [TMR_W-1:0] T_CS_INC = TMR_W'(CYC_CS_INC);
  localparam logic [TMR_W-1:0] T_DIR = TMR_W'(CYC_DIR_SETUP);
  localparam logic [TMR_W-1:0] T_LOW = TMR_W'(CYC_INC_LOW);
  localparam logic [TMR_W-1:0] T_HIGH = TMR_W'(CYC_INC_HIGH);
  localparam logic [TMR_W-1:0] T_INC_CS = TMR_W'(CYC_INC_CS);
  localparam logic [TMR_W-1:0] T_NOSTORE = TMR_W'(CYC_NOSTORE);
  localparam logic [TMR_W-1:0] T_STORE = TMR_W'(STORE_WAIT_CYC);
  localparam logic [TMR_W-1:0] T_ONE = TMR_W'(1);

  utc_host_s st_q;
  utc_host_s st_d;
  logic [CODE_W-1:0] live;
  logic tmr_done;
  utc_pin_if pins ();

  assign pins.sel_n = st_q.sel_n;
  assign pins.step_n = st_q.step_n;
  assign pins.dir_up = st_q.dir_up;

  // Tracks what the device should now hold, since the pins give no readback
  utc_model_track #(.UNITS_P(UNITS_P)) u_track (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .pins(pins),
    .recall_code(recall_code),
    .recall_load(recall_load),
    .live_code(live),
    .stored_code(nv_code),
    .unit_en(unit_en)
  );

  assign tmr_done = (st_q.tmr <= T_ONE);

  always_comb
  begin
    st_d = st_q;
    if (!tmr_done)
      st_d.tmr = st_q.tmr - T_ONE;
    case (st_q.fsm)
      UTC_IDLE:
      begin
        st_d.sel_n = 1'b1;
        st_d.step_n = 1'b1;
        if (cmd_valid && !recall_load)
        begin
          st_d.target = cmd_code;
          st_d.store = cmd_store;
          st_d.tmr = T_CS_INC;
          st_d.fsm = UTC_SEL;
          st_d.sel_n = 1'b0;
          if (!cmd_store && cmd_code == live)
          begin
            // Nothing to move or store; lowering step while selected would count a step
            st_d.sel_n = 1'b1;
            st_d.tmr = T_NOSTORE;
            st_d.fsm = UTC_WAIT;
          end
        end
      end
      UTC_SEL:
        if (tmr_done)
        begin
          // Direction is only changed with step high; select stays low
          st_d.dir_up = (st_q.target > live);
          st_d.tmr = T_DIR;
          st_d.fsm = (st_q.target == live) ? UTC_DESEL : UTC_DIR;
          if (st_q.target == live)
            st_d.tmr = T_INC_CS;
        end
      UTC_DIR:
        if (tmr_done)
        begin
          st_d.step_n = 1'b0;
          st_d.tmr = T_LOW;
          st_d.fsm = UTC_LOW;
        end
      UTC_LOW:
        if (tmr_done)
        begin
          if (st_q.target == live && !st_q.store)
          begin
            // Last step of a skip keeps step low, so no extra falling edge reaches the device
            st_d.tmr = T_INC_CS;
            st_d.fsm = UTC_DESEL;
          end
          else
          begin
            st_d.step_n = 1'b1;
            st_d.tmr = T_HIGH;
            st_d.fsm = UTC_HIGH;
          end
        end
      UTC_HIGH:
        if (tmr_done)
        begin
          if (st_q.target == live)
          begin
            // Only a storing run ends here; step stays high across the select edge
            st_d.step_n = st_q.store;
            st_d.tmr = T_INC_CS;
            st_d.fsm = UTC_DESEL;
          end
          else
          begin
            st_d.dir_up = (st_q.target > live);
            st_d.tmr = T_DIR;
            st_d.fsm = UTC_DIR;
          end
        end
      UTC_DESEL:
      begin
        st_d.step_n = st_q.store;
        if (tmr_done && st_q.step_n == st_q.store)
        begin
          // Step is held steady across the select edge
          st_d.sel_n = 1'b1;
          st_d.tmr = st_q.store ? T_STORE : T_NOSTORE;
          st_d.fsm = UTC_WAIT;
        end
      end
      UTC_WAIT:
        if (tmr_done)
        begin
          st_d.step_n = 1'b1;
          st_d.fsm = UTC_IDLE;
        end
      default:
      begin
        st_d.fsm = UTC_IDLE;
        st_d.sel_n = 1'b1;
        st_d.step_n = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      // Pins idle high from the first edge so the device sees no step or store
      st_q <= '{fsm: UTC_IDLE, tmr: '0, target: CODE_MIN, store: 1'b0,
                sel_n: 1'b1, step_n: 1'b1, dir_up: 1'b1};
    else if (ce)
      st_q <= st_d;
  end

  assign sel_n = st_q.sel_n;
  assign step_n = st_q.step_n;
  assign dir_up = st_q.dir_up;
  assign cmd_ready = (st_q.fsm == UTC_IDLE) && !recall_load;
  assign busy = (st_q.fsm != UTC_IDLE);
  assign cur_code = live;

  a_sel_idle_high: assert property (@(posedge clk) disable iff (rst)
    st_q.fsm == UTC_IDLE |-> st_q.sel_n && st_q.step_n)
    else $error("Pins not idle high");
  a_no_step_on_sel: assert property (@(posedge clk) disable iff (rst)
    $changed(st_q.sel_n) |-> $stable(st_q.step_n))
    else $error("Step moved with select");
  a_store_step_high: assert property (@(posedge clk) disable iff (rst)
    $rose(st_q.sel_n) && st_q.store |-> st_q.step_n)
    else $error("Store deselect with step low");
  a_skip_step_low: assert property (@(posedge clk) disable iff (rst)
    $rose(st_q.sel_n) && !st_q.store |-> !st_q.step_n)
    else $error("Skip deselect with step high");
  a_store_wait_held: assert property (@(posedge clk) disable iff (rst)
    $rose(st_q.sel_n) && st_q.store |-> st_q.tmr == T_STORE)
    else $error("Store wait too short");
  a_dir_stable_low: assert property (@(posedge clk) disable iff (rst)
    !st_q.step_n |-> $stable(st_q.dir_up))
    else $error("Direction moved while step low");
  a_step_only_sel: assert property (@(posedge clk) disable iff (rst)
    $fell(st_q.step_n) && st_q.fsm == UTC_LOW |-> !st_q.sel_n)
    else $error("Step strobe while deselected");
  a_low_width: assert property (@(posedge clk) disable iff (rst)
    ce && $fell(st_q.step_n) && st_q.fsm == UTC_LOW
    |-> st_q.tmr == T_LOW)
    else $error("Step low phase miscounted");

  c_store_done: cover property (@(posedge clk) $rose(st_q.sel_n) && st_q.store);
  c_skip_done: cover property (@(posedge clk) $rose(st_q.sel_n) && !st_q.store);
  c_top_code: cover property (@(posedge clk) live == CODE_MAX);
  c_dir_swap: cover property (@(posedge clk) !st_q.sel_n && $changed(st_q.dir_up));
endmodule

/* File: include/utc_pin_if.sv */
`timescale 1ns/1ps
interface utc_pin_if;
  logic sel_n;
  logic step_n;
  logic dir_up;
  modport drv (output sel_n, output step_n, output dir_up);
  modport mon (input sel_n, input step_n, input dir_up);
endinterface

/* File: include/utc_pkg.sv */
package utc_pkg;
  // Clock and pin timing, figures in ns except the store deselect time in ms
  localparam int CLK_PERIOD_NS = 5;
  localparam int T_CS_INC_NS = 100;
  localparam int T_DIR_SETUP_NS = 100;
  localparam int T_INC_LOW_NS = 1000;
  localparam int T_INC_HIGH_NS = 1000;
  localparam int T_INC_CYC_NS = 4000;
  localparam int T_INC_CS_NS = 1000;
  localparam int T_NOSTORE_NS = 1000;
  localparam int STORE_DESELECT_TIME_MS = 10;
  localparam int NS_PER_MS = 1000000;
  // Least times round up
  localparam int CYC_CS_INC = (T_CS_INC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_DIR_SETUP = (T_DIR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_INC_LOW = (T_INC_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_INC_HIGH_RAW = (T_INC_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_INC_CYC = (T_INC_CYC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // High phase stretched so that low plus high covers the whole step cycle
  localparam int CYC_INC_HIGH = (CYC_INC_CYC - CYC_INC_LOW > CYC_INC_HIGH_RAW) ?
                                (CYC_INC_CYC - CYC_INC_LOW) : CYC_INC_HIGH_RAW;
  localparam int CYC_INC_CS = (T_INC_CS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_NOSTORE = (T_NOSTORE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_STORE_WAIT =
    (STORE_DESELECT_TIME_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMR_W = 24;
  localparam int CODE_W = 5;
  localparam int UNITS = 31;
  localparam logic [CODE_W-1:0] CODE_MAX = 5'h1F;
  localparam logic [CODE_W-1:0] CODE_MIN = 5'h00;
  localparam logic [CODE_W-1:0] CODE_ONE = 5'h01;

  typedef enum logic [6:0] {
    UTC_IDLE = 7'h01,
    UTC_SEL = 7'h02,
    UTC_DIR = 7'h04,
    UTC_LOW = 7'h08,
    UTC_HIGH = 7'h10,
    UTC_DESEL = 7'h20,
    UTC_WAIT = 7'h40
  } utc_state_e;
endpackage

/* File: verification/testbench.sv */
`timescale 1ns/1ps
module testbench
  import utc_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic cmd_valid = 1'b0;
  logic [CODE_W-1:0] cmd_code = 5'h00;
  logic cmd_store = 1'b0;
  logic [CODE_W-1:0] recall_code = 5'h00;
  logic recall_load = 1'b0;
  logic cmd_ready, sel_n, step_n, dir_up, busy;
  logic [CODE_W-1:0] cur_code, nv_code, dev_code, dev_nv;
  logic [UNITS-1:0] unit_en, dev_units;
  int fails = 0;
  int checks = 0;

  always #2.5 clk = ~clk;

  utc_trim_host #(.STORE_WAIT_CYC(50)) utc_trim_host_i (
    .clk(clk), .rst(rst), .ce(ce),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_store(cmd_store),
    .cmd_ready(cmd_ready), .sel_n(sel_n), .step_n(step_n), .dir_up(dir_up),
    .recall_code(recall_code), .recall_load(recall_load), .busy(busy),
    .cur_code(cur_code), .nv_code(nv_code), .unit_en(unit_en)
  );

  utc_dev_model #(.NV_INIT(5'h03)) utc_dev_model_i (
    .sel_n(sel_n), .step_n(step_n), .dir_up(dir_up),
    .code_q(dev_code), .nv_q(dev_nv), .units(dev_units)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    if (fails == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  function automatic logic [31:0] therm(input int n);
    therm = (32'h1 << n) - 32'h1;
  endfunction

  // Compare host tracker, device state and switch enables against expectation
  task automatic check_state(input int code, input int nv);
    check({27'h0, cur_code}, code);
    check({27'h0, dev_code}, code);
    check({27'h0, nv_code}, nv);
    check({27'h0, dev_nv}, nv);
    check({1'b0, unit_en}, therm(code));
    check({1'b0, dev_units}, therm(code));
  endtask

  task automatic run_cmd(input logic [CODE_W-1:0] code, input logic store);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 1000)
    begin
      @(posedge clk);
      n++;
    end
    check({31'h0, cmd_ready}, 32'h1);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_code <= code;
    cmd_store <= store;
    @(posedge clk);
    cmd_valid <= 1'b0;
    #1;
    check({31'h0, busy}, 32'h1);
    check({31'h0, cmd_ready}, 32'h0);
    n = 0;
    while (busy !== 1'b0 && n < 60000)
    begin
      @(posedge clk);
      n++;
    end
    #1;
    check({31'h0, busy}, 32'h0);
    check({31'h0, sel_n}, 32'h1);
    check({31'h0, step_n}, 32'h1);
  endtask

  task automatic t_reset();
    #1;
    check({31'h0, sel_n}, 32'h1);
    check({31'h0, step_n}, 32'h1);
    check({31'h0, busy}, 32'h0);
  endtask

  // A command offered while the clock enable is low must not be taken
  task automatic t_freeze();
    @(posedge clk);
    ce <= 1'b0;
    cmd_valid <= 1'b1;
    cmd_code <= 5'h05;
    cmd_store <= 1'b1;
    repeat (10) @(posedge clk);
    #1;
    check({31'h0, busy}, 32'h0);
    check({31'h0, sel_n}, 32'h1);
    @(posedge clk);
    cmd_valid <= 1'b0;
    ce <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    check({31'h0, busy}, 32'h0);
    check_state(0, 0);
  endtask

  task automatic t_recall();
    @(posedge clk);
    recall_code <= 5'h03;
    recall_load <= 1'b1;
    @(posedge clk);
    recall_load <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    check_state(3, 3);
  endtask

  task automatic t_up_store();
    run_cmd(5'h1F, 1'b1);
    check_state(31, 31);
  endtask

  task automatic t_down_skip();
    run_cmd(5'h1D, 1'b0);
    check_state(29, 31);
    run_cmd(5'h1D, 1'b0);
    check_state(29, 31);
  endtask

  task automatic t_down_store();
    run_cmd(5'h00, 1'b1);
    check_state(0, 0);
  endtask

  initial
  begin
    repeat (80000) @(posedge clk);
    fails++;
    test_done();
  end

  initial
  begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_recall();
    t_up_store();
    t_down_skip();
    t_down_store();
    t_freeze();
    test_done();
  end
endmodule

/* File: verification/utc_dev_model.sv */
`timescale 1ns/1ps
module utc_dev_model
  import utc_pkg::*;
#(
  parameter logic [CODE_W-1:0] NV_INIT = 5'h03
)
(
  // Pins from the host
  input wire logic sel_n,
  input wire logic step_n,
  input wire logic dir_up,
  // Device state
  output logic [CODE_W-1:0] code_q,
  output logic [CODE_W-1:0] nv_q,
  output logic [UNITS-1:0] units
);
  // Power-up recall from the value that survived power-off
  initial
  begin
    nv_q = NV_INIT;
    code_q = NV_INIT;
  end

  // Strobes seen while deselected have no effect
  always @(negedge step_n)
    if (sel_n === 1'b0)
    begin
      if (dir_up === 1'b1 && code_q != CODE_MAX)
        code_q <= code_q + CODE_ONE;
      else if (dir_up === 1'b0 && code_q != CODE_MIN)
        code_q <= code_q - CODE_ONE;
    end

  // Step high at deselect stores, step low leaves the live code alone
  always @(posedge sel_n)
    if (step_n === 1'b1)
      nv_q <= code_q;

  // Thermometer: single-step moves only, so make and break coincide here
  always_comb
    for (int i = 0; i < UNITS; i++)
      units[i] = (i < code_q);
endmodule
